// ---- smcb_host_model.sv ----
`default_nettype none
module smcb_host_model (
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // Frame order from the bench
  input  wire logic                    go,
  input  wire smcb_pkg::smcb_fwd_req_s cmd,
  // Tagged frame toward the switch
  output smcb_pkg::smcb_fwd_req_s      req
);
  import smcb_pkg::*;
  smcb_fwd_req_s nxt;
  always_comb begin
    nxt = cmd;
    nxt.valid = 1'b1;
    nxt.src = 2'h0;
    nxt.cpu_tag = 1'b1;
    // A zero VID would read as priority tagged, so the spare bit 2 is raised.
    if (nxt.tag_vid == 12'h000) nxt.tag_vid[2] = 1'b1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) req <= '0;
    else if (go) req <= nxt;
    // Idle fields churn so that nothing can lean on a stale frame.
    else req <= {1'b0, ~req[$bits(req)-2:0]};
  end
endmodule : smcb_host_model
`default_nettype wire

// ---- smcb_pkg.sv ----
`default_nettype none
package smcb_pkg;
  localparam int unsigned NPORT          = 3;
  localparam int unsigned CNT_W          = 16;
  localparam int unsigned BLK_W          = 9;
  // Register byte offsets.
  localparam logic [7:0] OFS_MIRROR      = 8'h00;
  localparam logic [7:0] OFS_IKIND       = 8'h04;
  localparam logic [7:0] OFS_EKIND       = 8'h08;
  localparam logic [7:0] OFS_ICFG        = 8'h0C;
  localparam logic [7:0] OFS_RCFG        = 8'h10;
  localparam logic [7:0] OFS_DROP        = 8'h14;
  localparam logic [7:0] OFS_PAUSE       = 8'h18;
  localparam logic [7:0] OFS_RESUME      = 8'h1C;
  localparam logic [7:0] OFS_MLIM        = 8'h20;
  localparam logic [7:0] OFS_LCNT0       = 8'h24;
  localparam logic [7:0] OFS_FCNT0       = 8'h30;
  localparam logic [7:0] OFS_BSTAT       = 8'h3C;
  // Mirror configuration field positions.
  localparam int unsigned MIR_SNF_LSB    = 3;
  localparam int unsigned MIR_RX_EN      = 5;
  localparam int unsigned MIR_TX_EN      = 6;
  localparam int unsigned MIR_FILT_EN    = 7;
  localparam logic [1:0] SNF_NONE        = 2'h3;
  localparam logic [1:0] KIND_CPU        = 2'h3;
  localparam logic [1:0] DST_BCAST       = 2'h3;
  // Buffer store: 32 kB in 128 byte blocks.
  localparam int unsigned STORE_BYTES    = 32768;
  localparam int unsigned BLOCK_BYTES    = 128;
  localparam logic [BLK_W-1:0] NBLOCKS   = BLK_W'(STORE_BYTES / BLOCK_BYTES);
  localparam logic [4:0] MAX_PKT_BLKS    = 5'h10;
  localparam logic [10:0] MAX_TAGGED_LEN = 11'h5F2;
  // Thresholds used while at most one port is holding buffers.
  localparam logic [7:0] FIX_DROP        = 8'h40;
  localparam logic [7:0] FIX_PAUSE       = 8'h30;
  localparam logic [7:0] FIX_RESUME      = 8'h20;
  // Reset values.
  localparam logic [7:0] RST_MIRROR      = {3'h0, SNF_NONE, 3'h0};
  localparam logic [15:0] RST_DROP       = 16'h1828;
  localparam logic [15:0] RST_PAUSE      = 16'h101C;
  localparam logic [15:0] RST_RESUME     = 16'h0810;
  localparam logic [BLK_W-1:0] RST_MLIM  = 9'h040;

  typedef struct packed {
    logic        valid;
    logic [1:0]  src;
    logic [2:0]  dest;
    logic        filtered;
    logic        bcast_drop;
    logic        rate_drop;
    logic        learn_fail;
    logic [10:0] len;
    logic        cpu_tag;
    logic [2:0]  tag_pri;
    logic [11:0] tag_vid;
    logic [2:0]  lookup_dest;
    logic        lookup_ovr;
    logic [2:0]  class_pri;
    logic [2:0]  vlan_member;
    logic        cpu_state_ok;
  } smcb_fwd_req_s;

  typedef struct packed {
    logic       valid;
    logic [2:0] dest;
    logic [2:0] pri;
    logic       ovr;
    logic       learn;
    logic       strip;
    logic       drop;
  } smcb_fwd_rsp_s;

  typedef struct packed {
    logic       valid;
    logic [1:0] dst;
    logic [1:0] src;
    logic [2:0] class_pri;
    logic       igmp;
    logic       found;
    logic       stat;
    logic       ovr;
    logic       pri_en;
    logic [2:0] epri;
    logic       has_vlan;
    logic       from_cpu;
  } smcb_eg_req_s;

  typedef struct packed {
    logic        valid;
    logic        insert;
    logic [15:0] tag;
    logic        keep_vlan;
    logic        strip;
  } smcb_eg_rsp_s;

  typedef struct packed {
    logic       valid;
    logic [1:0] port;
    logic [4:0] blocks;
    logic       multi;
  } smcb_buf_req_s;
endpackage : smcb_pkg
`default_nettype wire

// ---- smcb_switch.sv ----
// Implementation choices: register access over APB and the register addresses.
`default_nettype none
module smcb_switch (
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  // Forwarding decision
  input  wire smcb_pkg::smcb_fwd_req_s fwd_req_i,
  output smcb_pkg::smcb_fwd_rsp_s      fwd_rsp_o,
  // Egress tag insertion
  input  wire smcb_pkg::smcb_eg_req_s  eg_req_i,
  output smcb_pkg::smcb_eg_rsp_s       eg_rsp_o,
  // Buffer allocation and release
  input  wire smcb_pkg::smcb_buf_req_s alloc_i,
  input  wire smcb_pkg::smcb_buf_req_s free_i,
  output logic                         alloc_ok_o,
  output logic                         alloc_drop_o,
  output logic [2:0]                   pause_o,
  output logic [2:0]                   drop_lim_o
);
  import smcb_pkg::*;

  typedef struct packed {
    logic [7:0]                   mirror;
    logic [5:0]                   ikind;
    logic [5:0]                   ekind;
    logic [5:0]                   icfg;
    logic [2:0]                   rcfg;
    logic [15:0]                  drop;
    logic [15:0]                  pause;
    logic [15:0]                  resume;
    logic [BLK_W-1:0]             mlim;
    logic [NPORT-1:0][CNT_W-1:0]  lcnt;
    logic [NPORT-1:0][CNT_W-1:0]  fcnt;
    logic [NPORT-1:0][BLK_W-1:0]  usage;
    logic [BLK_W-1:0]             free;
    logic [BLK_W-1:0]             multi;
    logic [2:0]                   pause_st;
    logic [2:0]                   drop_st;
    logic                         mdrop;
    logic                         pready;
    logic [31:0]                  prdata;
    logic                         pslverr;
    smcb_fwd_rsp_s                fwd;
    smcb_eg_rsp_s                 eg;
    logic                         aok;
    logic                         adrop;
  } smcb_state_s;

  smcb_state_s st_q;
  smcb_state_s st_d;

  logic [2:0]  base;
  logic [2:0]  snf;
  logic [2:0]  mir;
  logic [2:0]  srcm;
  logic        tagged_in;
  logic        filt;
  logic        oversize;
  logic        drop_pkt;
  logic [11:0] vid;
  logic [1:0]  act;
  logic [7:0]  thr_drop;
  logic [7:0]  thr_pause;
  logic [7:0]  thr_resume;
  logic [2:0]  rsel;
  logic        a_ok;

  always_comb begin
    st_d       = st_q;
    base       = 3'h0;
    snf        = 3'h0;
    mir        = 3'h0;
    srcm       = 3'h0;
    tagged_in  = 1'b0;
    filt       = 1'b0;
    oversize   = 1'b0;
    drop_pkt   = 1'b0;
    vid        = fwd_req_i.tag_vid;
    act        = 2'h0;
    thr_drop   = FIX_DROP;
    thr_pause  = FIX_PAUSE;
    thr_resume = FIX_RESUME;
    rsel       = 3'h0;
    a_ok       = 1'b0;

    // APB: one wait state, so every access completes on its second access-phase edge.
    st_d.pready  = 1'b0;
    st_d.pslverr = 1'b0;
    if (psel && penable && !st_q.pready) begin
      st_d.pready  = 1'b1;
      st_d.prdata  = 32'h0000_0000;
      case (paddr)
        OFS_MIRROR: st_d.prdata = {24'h0, st_q.mirror};
        OFS_IKIND:  st_d.prdata = {26'h0, st_q.ikind};
        OFS_EKIND:  st_d.prdata = {26'h0, st_q.ekind};
        OFS_ICFG:   st_d.prdata = {26'h0, st_q.icfg};
        OFS_RCFG:   st_d.prdata = {29'h0, st_q.rcfg};
        OFS_DROP:   st_d.prdata = {16'h0, st_q.drop};
        OFS_PAUSE:  st_d.prdata = {16'h0, st_q.pause};
        OFS_RESUME: st_d.prdata = {16'h0, st_q.resume};
        OFS_MLIM:   st_d.prdata = {23'h0, st_q.mlim};
        OFS_BSTAT:  st_d.prdata = {7'h0, st_q.multi, 7'h0, st_q.free};
        default: begin
          rsel = 3'h0;
          for (int p = 0; p < NPORT; p++) begin
            if (paddr == OFS_LCNT0 + 8'(4 * p)) begin
              st_d.prdata = {16'h0, st_q.lcnt[p]};
              rsel        = 3'h1;
            end
            if (paddr == OFS_FCNT0 + 8'(4 * p)) begin
              st_d.prdata = {16'h0, st_q.fcnt[p]};
              rsel        = 3'h1;
            end
          end
          // Counters are read only; writes to them and unmapped reads or writes error.
          st_d.pslverr = pwrite || (rsel == 3'h0);
        end
      endcase
      if (pwrite) begin
        case (paddr)
          OFS_MIRROR: st_d.mirror = pwdata[7:0];
          OFS_IKIND:  st_d.ikind  = pwdata[5:0];
          OFS_EKIND:  st_d.ekind  = pwdata[5:0];
          OFS_ICFG:   st_d.icfg   = pwdata[5:0];
          OFS_RCFG:   st_d.rcfg   = pwdata[2:0];
          OFS_DROP:   st_d.drop   = pwdata[15:0];
          OFS_PAUSE:  st_d.pause  = pwdata[15:0];
          OFS_RESUME: st_d.resume = pwdata[15:0];
          OFS_MLIM:   st_d.mlim   = pwdata[BLK_W-1:0];
          OFS_BSTAT:  st_d.pslverr = 1'b1;
          default:    st_d.pslverr = 1'b1;
        endcase
      end
    end

    // Forwarding decision, registered one cycle after the request.
    srcm      = 3'(3'h1 << fwd_req_i.src);
    tagged_in = fwd_req_i.cpu_tag && (st_q.ikind[2*fwd_req_i.src +: 2] == KIND_CPU);
    filt      = fwd_req_i.filtered || fwd_req_i.bcast_drop ||
                (tagged_in && st_q.icfg[3 + fwd_req_i.src] && vid == 12'h000);
    oversize  = tagged_in && !st_q.rcfg[fwd_req_i.src] &&
                (fwd_req_i.len > MAX_TAGGED_LEN);
    drop_pkt  = filt || oversize || fwd_req_i.rate_drop;
    st_d.fwd       = '0;
    st_d.fwd.valid = fwd_req_i.valid;
    st_d.fwd.pri   = fwd_req_i.class_pri;
    st_d.fwd.learn = !fwd_req_i.learn_fail && st_q.icfg[fwd_req_i.src];
    base           = fwd_req_i.dest;
    if (tagged_in) begin
      st_d.fwd.strip = 1'b1;
      if (!vid[3]) begin
        base          = (vid[1:0] == DST_BCAST) ? 3'h7 : 3'(3'h1 << vid[1:0]);
        st_d.fwd.ovr   = vid[4];
        st_d.fwd.learn = 1'b0;
      end else begin
        base           = fwd_req_i.lookup_dest;
        st_d.fwd.ovr   = fwd_req_i.lookup_ovr;
        st_d.fwd.learn = st_q.icfg[fwd_req_i.src] && fwd_req_i.cpu_state_ok;
      end
      st_d.fwd.pri = vid[5] ? fwd_req_i.class_pri : fwd_req_i.tag_pri;
      if (vid[6]) begin
        base = base & fwd_req_i.vlan_member;
      end
    end
    if (drop_pkt) begin
      base           = 3'h0;
      st_d.fwd.learn = 1'b0;
    end
    st_d.fwd.drop = drop_pkt;
    if (st_q.mirror[MIR_SNF_LSB +: 2] != SNF_NONE) begin
      snf = 3'(3'h1 << st_q.mirror[MIR_SNF_LSB +: 2]);
    end
    if (st_q.mirror[MIR_RX_EN] && (st_q.mirror[2:0] & srcm) != 3'h0 &&
        !oversize && !fwd_req_i.rate_drop &&
        (!filt || st_q.mirror[MIR_FILT_EN])) begin
      mir = snf;
    end
    if (st_q.mirror[MIR_TX_EN] && (st_q.mirror[2:0] & base) != 3'h0) begin
      mir = mir | snf;
    end
    st_d.fwd.dest = (base | mir) & ~srcm;

    // Per-port counters; they wrap and are never cleared by software.
    if (fwd_req_i.valid) begin
      if (fwd_req_i.learn_fail) begin
        st_d.lcnt[fwd_req_i.src] = st_q.lcnt[fwd_req_i.src] + CNT_W'(1);
      end
      if (filt && !fwd_req_i.rate_drop) begin
        st_d.fcnt[fwd_req_i.src] = st_q.fcnt[fwd_req_i.src] + CNT_W'(1);
      end
    end

    // Egress tag insertion toward the CPU port.
    st_d.eg           = '0;
    st_d.eg.valid     = eg_req_i.valid;
    st_d.eg.keep_vlan = eg_req_i.has_vlan;
    if (st_q.ekind[2*eg_req_i.dst +: 2] == KIND_CPU) begin
      st_d.eg.insert       = 1'b1;
      st_d.eg.tag[15:13]   = eg_req_i.class_pri;
      st_d.eg.tag[1:0]     = eg_req_i.src;
      st_d.eg.tag[3]       = eg_req_i.igmp;
      if (eg_req_i.found && eg_req_i.stat) begin
        st_d.eg.tag[9:4] = {eg_req_i.epri, eg_req_i.pri_en, 1'b1, eg_req_i.ovr};
      end
    end else begin
      st_d.eg.strip = eg_req_i.from_cpu;
    end

    // Thresholds follow the number of ports currently holding buffers.
    for (int p = 0; p < NPORT; p++) begin
      act = act + 2'(st_q.usage[p] != '0);
    end
    if (act == 2'h2) begin
      thr_drop   = st_q.drop[7:0];
      thr_pause  = st_q.pause[7:0];
      thr_resume = st_q.resume[7:0];
    end else if (act == 2'h3) begin
      thr_drop   = st_q.drop[15:8];
      thr_pause  = st_q.pause[15:8];
      thr_resume = st_q.resume[15:8];
    end
    for (int p = 0; p < NPORT; p++) begin
      if (st_q.usage[p] >= BLK_W'(thr_pause)) begin
        st_d.pause_st[p] = 1'b1;
      end else if (st_q.usage[p] <= BLK_W'(thr_resume)) begin
        st_d.pause_st[p] = 1'b0;
      end
      st_d.drop_st[p] = st_q.usage[p] >= BLK_W'(thr_drop);
    end
    st_d.mdrop = st_q.multi >= st_q.mlim;

    // Block allocation; a release in the same cycle is applied as well.
    a_ok = alloc_i.valid && alloc_i.blocks != 5'h00 && alloc_i.blocks <= MAX_PKT_BLKS &&
           BLK_W'(alloc_i.blocks) <= st_q.free && !st_q.drop_st[alloc_i.port] &&
           !(alloc_i.multi && st_q.mdrop);
    st_d.aok   = a_ok;
    st_d.adrop = alloc_i.valid && !a_ok;
    if (a_ok) begin
      st_d.free               = st_d.free - BLK_W'(alloc_i.blocks);
      st_d.usage[alloc_i.port] = st_d.usage[alloc_i.port] + BLK_W'(alloc_i.blocks);
      if (alloc_i.multi) begin
        st_d.multi = st_d.multi + BLK_W'(alloc_i.blocks);
      end
    end
    if (free_i.valid) begin
      st_d.free               = st_d.free + BLK_W'(free_i.blocks);
      st_d.usage[free_i.port] = st_d.usage[free_i.port] - BLK_W'(free_i.blocks);
      if (free_i.multi) begin
        st_d.multi = st_d.multi - BLK_W'(free_i.blocks);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q        <= '0;
      st_q.mirror <= RST_MIRROR;
      st_q.drop   <= RST_DROP;
      st_q.pause  <= RST_PAUSE;
      st_q.resume <= RST_RESUME;
      st_q.mlim   <= RST_MLIM;
      st_q.free   <= NBLOCKS;
    end else begin
      st_q <= st_d;
    end
  end

  assign pready       = st_q.pready;
  assign prdata       = st_q.prdata;
  assign pslverr      = st_q.pslverr;
  assign fwd_rsp_o    = st_q.fwd;
  assign eg_rsp_o     = st_q.eg;
  assign alloc_ok_o   = st_q.aok;
  assign alloc_drop_o = st_q.adrop;
  assign pause_o      = st_q.pause_st;
  assign drop_lim_o   = st_q.drop_st;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("APB access not answered after one wait state");
  a_no_echo_port: assert property (fwd_req_i.valid |=>
      (fwd_rsp_o.dest & 3'(3'h1 << $past(fwd_req_i.src))) == 3'h0)
    else $error("packet sent back to its receive port");
  a_rx_mirror_copy: assert property (fwd_req_i.valid && !drop_pkt && st_q.mirror[MIR_RX_EN] &&
      (st_q.mirror[2:0] & srcm) != 3'h0 && (snf & ~srcm) != 3'h0 |=>
      (fwd_rsp_o.dest & $past(snf)) != 3'h0)
    else $error("receive mirror copy missing");
  a_filt_no_mirror: assert property (fwd_req_i.valid && filt && !st_q.mirror[MIR_FILT_EN] |=>
      fwd_rsp_o.dest == 3'h0)
    else $error("filtered packet mirrored without option");
  a_tag_direct_dest: assert property (fwd_req_i.valid && tagged_in && !vid[3] && !vid[6] &&
      !drop_pkt && vid[1:0] != fwd_req_i.src && vid[1:0] != DST_BCAST |=>
      fwd_rsp_o.dest[$past(vid[1:0])] && fwd_rsp_o.ovr == $past(vid[4]))
    else $error("CPU tag direct destination wrong");
  a_tag_priority: assert property (fwd_req_i.valid && tagged_in && !vid[5] |=>
      fwd_rsp_o.pri == $past(fwd_req_i.tag_pri))
    else $error("CPU tag priority not used");
  a_oversize_drop: assert property (fwd_req_i.valid && oversize |=>
      fwd_rsp_o.drop && fwd_rsp_o.dest == 3'h0)
    else $error("oversize CPU frame not dropped");
  a_tag_attr_zero: assert property (eg_req_i.valid && !eg_req_i.found |=>
      eg_rsp_o.tag[9:4] == 6'h00)
    else $error("unknown address carried table attributes");
  a_tag_src_field: assert property (eg_req_i.valid &&
      st_q.ekind[2*eg_req_i.dst +: 2] == KIND_CPU |=>
      eg_rsp_o.insert && eg_rsp_o.tag[1:0] == $past(eg_req_i.src))
    else $error("inserted tag source port wrong");
  a_alloc_limit: assert property (alloc_ok_o |->
      $past(alloc_i.blocks) <= MAX_PKT_BLKS && $past(alloc_i.blocks) != 5'h00)
    else $error("allocation beyond per-packet block limit");
  a_multi_limit: assert property (st_q.multi >= st_q.mlim ##1 alloc_i.valid && alloc_i.multi
      |=> !alloc_ok_o)
    else $error("multi-destination packet accepted over limit");
  a_pause_hyst: assert property (pause_o[0] && st_q.usage[0] > BLK_W'(thr_resume) |=>
      pause_o[0])
    else $error("pause released above resume level");

  c_rx_mirror: cover property (fwd_rsp_o.valid && (fwd_rsp_o.dest & snf) != 3'h0);
  c_cpu_insert: cover property (eg_rsp_o.valid && eg_rsp_o.insert);
  c_pause_on: cover property ($rose(pause_o[1]));
  c_alloc_drop: cover property (alloc_drop_o);
endmodule : smcb_switch
`default_nettype wire

// ---- tb_switch_mirror_cputag_buffer.sv ----
`default_nettype none
module tb_switch_mirror_cputag_buffer;
  timeunit 1ns;
  timeprecision 1ps;
  import smcb_pkg::*;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, hgo, err;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, rd;
  logic [2:0]    pause_w, dlim_w;
  logic [1:0]    ab, ab_w;
  logic [8:0]    fv;
  smcb_fwd_req_s treq, hcmd, hreq, fwd_req, r;
  smcb_fwd_rsp_s fo, fo_w;
  smcb_eg_req_s  ereq, e;
  smcb_eg_rsp_s  eo, eo_w;
  smcb_buf_req_s areq, freq;
  int            n_fail, n_tests;
  localparam logic [7:0]  ROFS [6] = '{OFS_MIRROR, OFS_DROP, OFS_PAUSE, OFS_RESUME, OFS_MLIM,
                                       OFS_BSTAT};
  localparam logic [31:0] REXP [6] = '{32'(RST_MIRROR), 32'(RST_DROP), 32'(RST_PAUSE),
                                       32'(RST_RESUME), 32'(RST_MLIM), 32'(NBLOCKS)};
  // Tag VID, then expected {dest, pri, ovr, learn, strip}.
  localparam logic [20:0] CT [6] = '{{12'h001, 9'h0A9}, {12'h012, 9'h12D}, {12'h003, 9'h1A9},
                                     {12'h008, 9'h12F}, {12'h021, 9'h091}, {12'h043, 9'h0A9}};
  assign fwd_req = treq.valid ? treq : hreq;
  smcb_host_model u_host (.pclk(pclk), .presetn(presetn), .go(hgo), .cmd(hcmd), .req(hreq));
  smcb_switch u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .fwd_req_i(fwd_req), .fwd_rsp_o(fo_w), .eg_req_i(ereq), .eg_rsp_o(eo_w), .alloc_i(areq),
    .free_i(freq), .alloc_ok_o(ab_w[1]), .alloc_drop_o(ab_w[0]), .pause_o(pause_w),
    .drop_lim_o(dlim_w));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic pkt(input logic host, input smcb_fwd_req_s f, input smcb_eg_req_s g);
    @(posedge pclk);
    if (host) hcmd <= f;
    hgo <= host;
    if (!host) treq <= f;
    ereq <= g;
    @(posedge pclk);
    hgo <= 1'b0;
    treq.valid <= 1'b0;
    ereq.valid <= 1'b0;
    @(posedge pclk);
    eo = eo_w;
    if (host) @(posedge pclk);
    fo = fo_w;
  endtask : pkt
  task automatic blk(input logic rel, input logic [1:0] p, input logic [4:0] n, input logic m);
    @(posedge pclk);
    if (rel) freq <= {1'b1, p, n, m};
    else areq <= {1'b1, p, n, m};
    @(posedge pclk);
    areq.valid <= 1'b0;
    freq.valid <= 1'b0;
    @(posedge pclk);
    ab = ab_w;
  endtask : blk
  function automatic smcb_fwd_req_s fr(input logic [1:0] s, input logic [2:0] d, input logic f);
    fr = '0;
    fr.valid = 1'b1;
    fr.src = s;
    fr.dest = d;
    fr.filtered = f;
    fr.len = 11'd64;
    fr.vlan_member = 3'b111;
    fr.cpu_state_ok = 1'b1;
  endfunction : fr
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    end_of_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, hgo} = '0;
    {treq, hcmd, ereq, areq, freq} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ROFS[i]) begin
      apb(1'b0, ROFS[i], 32'h0);
      check(rd, REXP[i]);
    end
    apb(1'b0, 8'h40, 32'h0);
    check(err, 1'b1);
    apb(1'b1, OFS_LCNT0, 32'h5);
    check(err, 1'b1);
    $display("registers done");
    apb(1'b1, OFS_MIRROR, 32'h24);
    pkt(1'b0, fr(2'd2, 3'b010, 1'b0), '0);
    check({fo.valid, fo.dest}, 4'b1011);
    pkt(1'b0, fr(2'd2, 3'b010, 1'b1), '0);
    check({fo.dest, fo.drop}, 4'b0001);
    apb(1'b1, OFS_MIRROR, 32'hA4);
    pkt(1'b0, fr(2'd2, 3'b010, 1'b1), '0);
    check(fo.dest, 3'b001);
    r = fr(2'd2, 3'b010, 1'b0);
    r.bcast_drop = 1'b1;
    pkt(1'b0, r, '0);
    r.bcast_drop = 1'b0;
    r.rate_drop = 1'b1;
    pkt(1'b0, r, '0);
    apb(1'b0, OFS_FCNT0 + 8'h08, 32'h0);
    check(rd, 32'h3);
    r = fr(2'd1, 3'b001, 1'b0);
    r.learn_fail = 1'b1;
    pkt(1'b0, r, '0);
    apb(1'b0, OFS_LCNT0 + 8'h04, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, OFS_MIRROR, 32'h27);
    pkt(1'b0, fr(2'd0, 3'b010, 1'b0), '0);
    check(fo.dest, 3'b010);
    apb(1'b1, OFS_MIRROR, 32'h4C);
    pkt(1'b0, fr(2'd0, 3'b100, 1'b0), '0);
    check(fo.dest, 3'b110);
    apb(1'b1, OFS_MIRROR, 32'h6D);
    pkt(1'b0, fr(2'd2, 3'b001, 1'b0), '0);
    check(fo.dest, 3'b011);
    $display("mirror done");
    apb(1'b1, OFS_MIRROR, 32'h18);
    apb(1'b1, OFS_IKIND, 32'h3);
    apb(1'b1, OFS_ICFG, 32'h1);
    r = fr(2'd0, 3'b000, 1'b0);
    r.tag_pri = 3'h5;
    r.class_pri = 3'h2;
    r.lookup_dest = 3'b100;
    r.lookup_ovr = 1'b1;
    r.vlan_member = 3'b010;
    foreach (CT[i]) begin
      r.tag_vid = CT[i][20:9];
      pkt(1'b1, r, '0);
      fv = {fo.dest, fo.pri, fo.ovr, fo.learn, fo.strip};
      check(fv, CT[i][8:0]);
    end
    r.tag_vid = 12'h008;
    r.cpu_state_ok = 1'b0;
    pkt(1'b1, r, '0);
    check(fo.learn, 1'b0);
    r.tag_vid = 12'h001;
    r.len = 11'd1523;
    pkt(1'b1, r, '0);
    check(fo.drop, 1'b1);
    r.len = 11'd1522;
    pkt(1'b1, r, '0);
    check(fo.drop, 1'b0);
    apb(1'b1, OFS_RCFG, 32'h1);
    r.len = 11'd1523;
    pkt(1'b1, r, '0);
    check(fo.drop, 1'b0);
    apb(1'b1, OFS_ICFG, 32'h9);
    r.tag_vid = 12'h000;
    r.len = 11'h040;
    pkt(1'b1, r, '0);
    check(fo.drop, 1'b0);
    r.cpu_tag = 1'b1;
    pkt(1'b0, r, '0);
    check(fo.drop, 1'b1);
    $display("cpu ingress done");
    apb(1'b1, OFS_EKIND, 32'h3);
    e = {1'b1, 2'd0, 2'd2, 3'd5, 4'b1111, 1'b0, 3'd6, 1'b1, 1'b0};
    pkt(1'b0, '0, e);
    check({eo.insert, eo.tag, eo.keep_vlan}, {1'b1, 16'hA33A, 1'b1});
    e.stat = 1'b0;
    pkt(1'b0, '0, e);
    check(eo.tag, 16'hA00A);
    e.from_cpu = 1'b1;
    e.dst = 2'd1;
    pkt(1'b0, '0, e);
    check({eo.valid, eo.insert, eo.strip}, 3'b101);
    $display("cpu egress done");
    apb(1'b1, OFS_MLIM, 32'h1);
    blk(1'b0, 2'd2, 5'd17, 1'b0);
    check(ab, 2'b01);
    blk(1'b0, 2'd2, 5'd16, 1'b0);
    check(ab, 2'b10);
    blk(1'b0, 2'd2, 5'd1, 1'b1);
    blk(1'b0, 2'd2, 5'd1, 1'b1);
    check(ab, 2'b01);
    apb(1'b0, OFS_BSTAT, 32'h0);
    check(rd, 32'h000100EF);
    blk(1'b1, 2'd2, 5'd16, 1'b0);
    blk(1'b1, 2'd2, 5'd1, 1'b1);
    repeat (3) blk(1'b0, 2'd1, 5'd16, 1'b0);
    repeat (2) @(posedge pclk);
    check({pause_w, dlim_w}, 6'b010000);
    blk(1'b0, 2'd1, 5'd16, 1'b0);
    repeat (2) @(posedge pclk);
    check(dlim_w, 3'b010);
    blk(1'b0, 2'd1, 5'd1, 1'b0);
    check(ab, 2'b01);
    repeat (3) blk(1'b1, 2'd1, 5'd16, 1'b0);
    repeat (2) @(posedge pclk);
    check({pause_w, dlim_w}, 6'b000000);
    // Three active ports switch to the upper programmed levels.
    blk(1'b0, 2'd0, 5'd16, 1'b0);
    blk(1'b0, 2'd2, 5'd16, 1'b0);
    repeat (2) @(posedge pclk);
    check({pause_w, dlim_w}, 6'b111000);
    $display("buffer done");
    end_of_test();
  end
endmodule : tb_switch_mirror_cputag_buffer
`default_nettype wire
